/* File: hdl/etc_timer_map.vh */
`ifndef ETC_TIMER_MAP_VH
`define ETC_TIMER_MAP_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define ETC_ADDR_CONTROL 8'h00
`define ETC_ADDR_COUNT 8'h04
`define ETC_ADDR_COMPARE 8'h08
`define ETC_ADDR_FLAG 8'h0C
`define ETC_ADDR_MASK 8'h10
`define ETC_ADDR_STATUS 8'h14

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define ETC_CS_LSB 0
`define ETC_CS_MSB 2
`define ETC_WGM_LSB 3
`define ETC_WGM_MSB 4
`define ETC_COM_LSB 5
`define ETC_COM_MSB 6
`define ETC_FOC_BIT 7

// ----------------------------------------------------------------
// Flag, mask and status fields
// ----------------------------------------------------------------
`define ETC_OVF_BIT 0
`define ETC_OCF_BIT 1
`define ETC_GIE_BIT 2

// ----------------------------------------------------------------
// Encodings and reset values
// ----------------------------------------------------------------
`define ETC_CS_STOP 3'h0
`define ETC_CS_DIV1 3'h1
`define ETC_CS_DIV8 3'h2
`define ETC_CS_DIV64 3'h3
`define ETC_CS_DIV256 3'h4
`define ETC_CS_DIV1024 3'h5
`define ETC_CS_EXT_FALL 3'h6
`define ETC_CS_EXT_RISE 3'h7
`define ETC_WGM_NORMAL 2'h0
`define ETC_WGM_PHASE 2'h1
`define ETC_WGM_CTC 2'h2
`define ETC_WGM_FAST 2'h3
`define ETC_COM_NONE 2'h0
`define ETC_COM_TOGGLE 2'h1
`define ETC_COM_CLEAR 2'h2
`define ETC_COM_SET 2'h3
`define ETC_BOTTOM 8'h00
`define ETC_MAX 8'hFF
`define ETC_RESET_BYTE 8'h00
`define ETC_PRESCALE_WRAP 10'h3FF

`endif

/* File: hdl/etc_timer.v */
// Register access over APB and the address map were decided locally.
`include "etc_timer_map.vh"

// Contract
// - Counter and compare storage are 8 bits
// - Tick from prescaler or external pin
// - Source select zero stops the counter
// - Tick clears, increments or decrements by one
// - Software may access counter anytime
// - Counter write beats clear or count
// - Flag bottom at 0x00, max at 0xFF
// - Top is 0xFF or compare value
// - Overflow flag set per waveform mode
// - Match sets flag on following tick
// - Compare irq needs flag, enable, global
// - Flag cleared by service or write one
// - Output driven from match and action
// - Compare double buffered in PWM modes
// - Buffer copied only at MAX (0xFF)
// - Access hits buffer or active register
// - Force strobe updates output in non-PWM modes, no flag
// - Counter write blocks next tick match
// - Output state kept across mode change
// - Action bits take effect immediately
// - Mode 0 normal, 2 ctc, 3 fast
// - Action zero leaves output untouched
// - Reset forces output state to zero
module etc_timer (
    // Clock and reset
    input wire clk_i,
    input wire sys_rst_i,
    // APB slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [7:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    // Board and core side
    input wire external_count_pin_i,
    input wire cpu_irq_ack_ovf_i,
    input wire cpu_irq_ack_cmp_i,
    output reg compare_output_o,
    output reg overflow_irq_o,
    output reg compare_irq_o
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    reg [2:0] clock_source_select_reg;
    reg [1:0] waveform_mode_select_reg;
    reg [1:0] compare_output_action_reg;
    reg [7:0] timer_count_value_reg;
    reg [7:0] compare_value_reg;
    reg [7:0] compare_buffer_reg;
    reg overflow_flag_reg;
    reg compare_match_flag_reg;
    reg overflow_irq_enable_reg;
    reg compare_irq_enable_reg;
    reg global_irq_enable_reg;
    reg count_down_reg;
    reg block_match_reg;
    reg match_pending_reg;
    reg compare_state_reg;
    reg [9:0] prescale_reg;
    reg ext_sync1_reg;
    reg ext_sync2_reg;
    reg ext_prev_reg;

    // Decoded strobes
    wire apb_access = psel_i & penable_i & pready_o;
    wire apb_write = apb_access & pwrite_i;
    wire wr_control = apb_write & (paddr_i == `ETC_ADDR_CONTROL);
    wire wr_count = apb_write & (paddr_i == `ETC_ADDR_COUNT);
    wire wr_compare = apb_write & (paddr_i == `ETC_ADDR_COMPARE);
    wire wr_flag = apb_write & (paddr_i == `ETC_ADDR_FLAG);
    wire wr_mask = apb_write & (paddr_i == `ETC_ADDR_MASK);
    wire wr_status = apb_write & (paddr_i == `ETC_ADDR_STATUS);

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------
    // PWM modes double buffer the compare value
    function is_pwm;
        input [1:0] mode;
        begin
            is_pwm = (mode == `ETC_WGM_PHASE) || (mode == `ETC_WGM_FAST);
        end
    endfunction

    // Known register addresses
    function addr_mapped;
        input [7:0] addr;
        begin
            addr_mapped = (addr == `ETC_ADDR_CONTROL) || (addr == `ETC_ADDR_COUNT) ||
                (addr == `ETC_ADDR_COMPARE) || (addr == `ETC_ADDR_FLAG) ||
                (addr == `ETC_ADDR_MASK) || (addr == `ETC_ADDR_STATUS);
        end
    endfunction

    // Level an action code drives the output to on a match
    function action_level;
        input [1:0] action;
        input [1:0] mode;
        input current;
        begin
            case (action)
                `ETC_COM_TOGGLE: action_level = is_pwm(mode) ? current : ~current;
                `ETC_COM_CLEAR: action_level = 1'b0;
                `ETC_COM_SET: action_level = 1'b1;
                default: action_level = current;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // Clock select and tick generation
    // ----------------------------------------------------------------
    wire pwm_mode = is_pwm(waveform_mode_select_reg);
    wire ext_rise = ext_sync2_reg & ~ext_prev_reg;
    wire ext_fall = ~ext_sync2_reg & ext_prev_reg;
    reg timer_tick;

    // Prescaler free-runs; the taps give one-cycle enables
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prescale_reg <= 10'h000;
            ext_sync1_reg <= 1'b0;
            ext_sync2_reg <= 1'b0;
            ext_prev_reg <= 1'b0;
        end else begin
            prescale_reg <= prescale_reg + 10'h001;
            ext_sync1_reg <= external_count_pin_i;
            ext_sync2_reg <= ext_sync1_reg;
            ext_prev_reg <= ext_sync2_reg;
        end
    end

    // Pick the tick source from the select field
    always @* begin
        case (clock_source_select_reg)
            `ETC_CS_STOP: timer_tick = 1'b0;
            `ETC_CS_DIV1: timer_tick = 1'b1;
            `ETC_CS_DIV8: timer_tick = (prescale_reg[2:0] == 3'h7);
            `ETC_CS_DIV64: timer_tick = (prescale_reg[5:0] == 6'h3F);
            `ETC_CS_DIV256: timer_tick = (prescale_reg[7:0] == 8'hFF);
            `ETC_CS_DIV1024: timer_tick = (prescale_reg == `ETC_PRESCALE_WRAP);
            `ETC_CS_EXT_FALL: timer_tick = ext_fall;
            `ETC_CS_EXT_RISE: timer_tick = ext_rise;
            default: timer_tick = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // Counter unit
    // ----------------------------------------------------------------
    wire at_bottom = (timer_count_value_reg == `ETC_BOTTOM);
    wire at_max = (timer_count_value_reg == `ETC_MAX);
    wire top_is_compare = (waveform_mode_select_reg == `ETC_WGM_CTC);
    wire [7:0] top_value = top_is_compare ? compare_value_reg : `ETC_MAX;
    wire at_top = (timer_count_value_reg == top_value);
    wire raw_match = (timer_count_value_reg == compare_value_reg);
    wire match_ok = raw_match & ~block_match_reg;
    reg [7:0] count_next;
    reg down_next;
    reg ovf_event;

    // Next count, direction and overflow per mode
    always @* begin
        count_next = timer_count_value_reg;
        down_next = count_down_reg;
        ovf_event = 1'b0;
        case (waveform_mode_select_reg)
            `ETC_WGM_PHASE: begin
                if (count_down_reg && at_bottom) begin
                    down_next = 1'b0;
                    count_next = timer_count_value_reg + 8'h01;
                    ovf_event = 1'b1;
                end else if (!count_down_reg && at_max) begin
                    down_next = 1'b1;
                    count_next = timer_count_value_reg - 8'h01;
                end else if (count_down_reg) begin
                    count_next = timer_count_value_reg - 8'h01;
                end else begin
                    count_next = timer_count_value_reg + 8'h01;
                end
            end
            `ETC_WGM_CTC: begin
                down_next = 1'b0;
                if (at_top) begin
                    count_next = `ETC_BOTTOM;
                end else begin
                    count_next = timer_count_value_reg + 8'h01;
                end
                ovf_event = at_max;
            end
            default: begin
                down_next = 1'b0;
                count_next = timer_count_value_reg + 8'h01;
                ovf_event = at_max;
            end
        endcase
    end

    // Software write wins over any tick in the same cycle
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            timer_count_value_reg <= `ETC_RESET_BYTE;
            count_down_reg <= 1'b0;
            block_match_reg <= 1'b0;
        end else begin
            if (wr_count) begin
                timer_count_value_reg <= pwdata_i[7:0];
                block_match_reg <= 1'b1;
            end else if (timer_tick) begin
                timer_count_value_reg <= count_next;
                count_down_reg <= down_next;
                block_match_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Output compare unit
    // ----------------------------------------------------------------
    // Buffer reloads at top (fast) or at the turn (phase correct)
    wire reload_point = (waveform_mode_select_reg == `ETC_WGM_FAST) ? at_max :
        (!count_down_reg && at_max);

    // Buffered writes go to the shadow, else straight through
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            compare_value_reg <= `ETC_RESET_BYTE;
            compare_buffer_reg <= `ETC_RESET_BYTE;
        end else begin
            if (wr_compare) begin
                compare_buffer_reg <= pwdata_i[7:0];
            end
            if (!pwm_mode) begin
                if (wr_compare) begin
                    compare_value_reg <= pwdata_i[7:0];
                end
            end else if (timer_tick && reload_point) begin
                compare_value_reg <= compare_buffer_reg;
            end
        end
    end

    // Match is held until the next tick lands it in the flag
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            match_pending_reg <= 1'b0;
        end else if (timer_tick | wr_count) begin
            match_pending_reg <= 1'b0;
        end else if (match_ok) begin
            match_pending_reg <= 1'b1;
        end
    end

    wire match_tick = timer_tick & (match_ok | match_pending_reg);
    wire force_hit = wr_control & pwdata_i[`ETC_FOC_BIT] & ~is_pwm(pwdata_i[4:3]);
    reg oc_next;

    // Waveform generator; mode changes never touch the state
    always @* begin
        oc_next = compare_state_reg;
        case (waveform_mode_select_reg)
            `ETC_WGM_FAST: begin
                if (compare_output_action_reg[1] && timer_tick && at_max) begin
                    oc_next = ~compare_output_action_reg[0];
                end else if (match_tick) begin
                    oc_next = action_level(compare_output_action_reg,
                        waveform_mode_select_reg, compare_state_reg);
                end
            end
            `ETC_WGM_PHASE: begin
                if (match_tick && compare_output_action_reg[1]) begin
                    oc_next = compare_output_action_reg[0] ^ count_down_reg;
                end
            end
            default: begin
                if (match_tick) begin
                    oc_next = action_level(compare_output_action_reg,
                        waveform_mode_select_reg, compare_state_reg);
                end
            end
        endcase
        if (force_hit) begin
            oc_next = action_level(pwdata_i[6:5], pwdata_i[4:3], compare_state_reg);
        end
    end

    // Output state register
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            compare_state_reg <= 1'b0;
            compare_output_o <= 1'b0;
        end else begin
            compare_state_reg <= oc_next;
            compare_output_o <= oc_next;
        end
    end

    // ----------------------------------------------------------------
    // Control, flags and interrupt requests
    // ----------------------------------------------------------------
    // Set beats clear on every flag
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            clock_source_select_reg <= `ETC_CS_STOP;
            waveform_mode_select_reg <= `ETC_WGM_NORMAL;
            compare_output_action_reg <= `ETC_COM_NONE;
            overflow_flag_reg <= 1'b0;
            compare_match_flag_reg <= 1'b0;
            overflow_irq_enable_reg <= 1'b0;
            compare_irq_enable_reg <= 1'b0;
            global_irq_enable_reg <= 1'b0;
            overflow_irq_o <= 1'b0;
            compare_irq_o <= 1'b0;
        end else begin
            if (wr_control) begin
                clock_source_select_reg <= pwdata_i[`ETC_CS_MSB:`ETC_CS_LSB];
                waveform_mode_select_reg <= pwdata_i[`ETC_WGM_MSB:`ETC_WGM_LSB];
                compare_output_action_reg <= pwdata_i[`ETC_COM_MSB:`ETC_COM_LSB];
            end
            if (wr_mask) begin
                overflow_irq_enable_reg <= pwdata_i[`ETC_OVF_BIT];
                compare_irq_enable_reg <= pwdata_i[`ETC_OCF_BIT];
            end
            if (wr_status) begin
                global_irq_enable_reg <= pwdata_i[`ETC_GIE_BIT];
            end
            if (timer_tick && ovf_event && !wr_count) begin
                overflow_flag_reg <= 1'b1;
            end else if (cpu_irq_ack_ovf_i || (wr_flag && pwdata_i[`ETC_OVF_BIT])) begin
                overflow_flag_reg <= 1'b0;
            end
            if (match_tick) begin
                compare_match_flag_reg <= 1'b1;
            end else if (cpu_irq_ack_cmp_i || (wr_flag && pwdata_i[`ETC_OCF_BIT])) begin
                compare_match_flag_reg <= 1'b0;
            end
            overflow_irq_o <= overflow_flag_reg & overflow_irq_enable_reg &
                global_irq_enable_reg;
            compare_irq_o <= compare_match_flag_reg & compare_irq_enable_reg &
                global_irq_enable_reg;
        end
    end

    // ----------------------------------------------------------------
    // APB slave: no wait states, read data registered
    // ----------------------------------------------------------------
    reg [31:0] read_mux;

    // Compare reads show the buffer when buffering is on
    always @* begin
        case (paddr_i)
            `ETC_ADDR_CONTROL: read_mux = {25'h0000000, compare_output_action_reg,
                waveform_mode_select_reg, clock_source_select_reg};
            `ETC_ADDR_COUNT: read_mux = {24'h000000, timer_count_value_reg};
            `ETC_ADDR_COMPARE: read_mux = {24'h000000,
                pwm_mode ? compare_buffer_reg : compare_value_reg};
            `ETC_ADDR_FLAG: read_mux = {30'h00000000, compare_match_flag_reg,
                overflow_flag_reg};
            `ETC_ADDR_MASK: read_mux = {30'h00000000, compare_irq_enable_reg,
                overflow_irq_enable_reg};
            `ETC_ADDR_STATUS: read_mux = {28'h0000000, compare_state_reg,
                global_irq_enable_reg, at_max, at_bottom};
            default: read_mux = 32'h00000000;
        endcase
    end

    // Ready rises in the first access cycle, held for one edge
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h00000000;
        end else begin
            if (psel_i && !penable_i) begin
                pready_o <= 1'b1;
                pslverr_o <= ~addr_mapped(paddr_i);
                prdata_o <= pwrite_i ? 32'h00000000 : read_mux;
            end else begin
                pready_o <= 1'b0;
                pslverr_o <= 1'b0;
            end
        end
    end

endmodule

/* File: sim/etc_timer_checker.sv */
module etc_timer_checker (
    // Clock and reset
    input wire clk_i,
    input wire sys_rst_i,
    // Register bus
    input wire psel_i,
    input wire penable_i,
    input wire [31:0] prdata_o,
    input wire pready_o,
    input wire pslverr_o,
    // Core side
    input wire cpu_irq_ack_ovf_i,
    input wire cpu_irq_ack_cmp_i,
    input wire compare_output_o,
    input wire overflow_irq_o,
    input wire compare_irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Port relations
    // ------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // Ready lands in the cycle after setup and stands only one cycle
    a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no ready after setup");
    a_ready_single: assert property (pready_o |=> !pready_o)
        else $error("ready held too long");
    a_ready_in_access: assert property (pready_o |-> psel_i && penable_i)
        else $error("ready outside access");
    a_err_with_ready: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    a_upper_zero: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
        else $error("read data above bit 7");
    a_reset_quiet: assert property ($fell(sys_rst_i) |->
        !compare_output_o && !compare_irq_o && !overflow_irq_o)
        else $error("outputs not cleared by reset");
    // Service drops the request within two cycles
    a_cmp_ack_clears: assert property (cpu_irq_ack_cmp_i |-> ##2 !compare_irq_o)
        else $error("compare request stays after service");
    a_ovf_ack_clears: assert property (cpu_irq_ack_ovf_i |-> ##2 !overflow_irq_o)
        else $error("overflow request stays after service");
endmodule

bind etc_timer etc_timer_checker i_chk (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .cpu_irq_ack_ovf_i(cpu_irq_ack_ovf_i),
    .cpu_irq_ack_cmp_i(cpu_irq_ack_cmp_i),
    .compare_output_o(compare_output_o),
    .overflow_irq_o(overflow_irq_o),
    .compare_irq_o(compare_irq_o)
);

/* File: sim/etc_far_model.sv */
module etc_far_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bench controls
    input wire logic pulse_en_i,
    input wire logic ack_en_i,
    // Timer side
    input wire logic compare_irq_i,
    input wire logic overflow_irq_i,
    output logic pin_o,
    output logic ack_ovf_o,
    output logic ack_cmp_o,
    output int pulses_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Count pin and interrupt service
    // ------------------------------------------------------------
    logic [2:0] phase_reg;
    // Three cycles high, three low: slow enough for the two-flop sync
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase_reg <= 3'h0;
            pin_o <= 1'b0;
            pulses_o <= 0;
        end else if (pulse_en_i || phase_reg != 3'h0) begin
            phase_reg <= (phase_reg == 3'h5) ? 3'h0 : phase_reg + 3'h1;
            pin_o <= (phase_reg < 3'h3);
            if (phase_reg == 3'h5) begin
                pulses_o <= pulses_o + 1;
            end
        end
    end
    // Service pulse on every other cycle while the request stands
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_ovf_o <= 1'b0;
            ack_cmp_o <= 1'b0;
        end else begin
            ack_cmp_o <= ack_en_i && compare_irq_i && !ack_cmp_o;
            ack_ovf_o <= ack_en_i && overflow_irq_i && !ack_ovf_o;
        end
    end
endmodule

/* File: sim/test_eight_bit_timer_compare_unit.sv */
`include "etc_timer_map.vh"
module test_eight_bit_timer_compare_unit;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Bench signals
    // ------------------------------------------------------------
    localparam logic [7:0] A_CTL = `ETC_ADDR_CONTROL;
    localparam logic [7:0] A_CNT = `ETC_ADDR_COUNT;
    localparam logic [7:0] A_CMP = `ETC_ADDR_COMPARE;
    localparam logic [7:0] A_FLG = `ETC_ADDR_FLAG;
    logic clk_i, sys_rst_i, psel, penable, pwrite, pulse_en, ack_en, err_q;
    logic [7:0] paddr;
    logic [31:0] pwdata, rd_q, v, base, seed;
    wire [31:0] prdata;
    wire pready, pslverr, ext_pin, ack_ovf, ack_cmp, cmp_out, ovf_irq, cmp_irq;
    int num_errors, n_tests, pulses;
    int acts[5] = '{3, 1, 1, 0, 2};
    logic [31:0] exps[5] = '{32'h1, 32'h0, 32'h1, 32'h1, 32'h0};

    etc_timer i_dut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .external_count_pin_i(ext_pin),
        .cpu_irq_ack_ovf_i(ack_ovf), .cpu_irq_ack_cmp_i(ack_cmp),
        .compare_output_o(cmp_out), .overflow_irq_o(ovf_irq), .compare_irq_o(cmp_irq));
    etc_far_model i_far (
        .clk_i(clk_i), .rst_i(sys_rst_i), .pulse_en_i(pulse_en), .ack_en_i(ack_en),
        .compare_irq_i(cmp_irq), .overflow_irq_i(ovf_irq), .pin_o(ext_pin),
        .ack_ovf_o(ack_ovf), .ack_cmp_o(ack_cmp), .pulses_o(pulses));

    always #5 clk_i = ~clk_i;

    // ------------------------------------------------------------
    // Tasks and functions
    // ------------------------------------------------------------
    task automatic test_done();
        $display("errors %0d, checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic stuck();
        num_errors++;
        $display("[FAIL] %0t wait ran out", $time);
        test_done();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; an idle edge first keeps psel from two writes per step
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (pready !== 1'b1 && k < 16);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) stuck();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd_q, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // Poll the counter until it sits in [lim, 0xC0)
    task automatic poll(input logic [31:0] lim);
        int k;
        k = 0;
        do begin
            bus(1'b0, A_CNT, 32'h0);
            k++;
        end while (!(rd_q >= lim && rd_q < 32'hC0) && k < 3000);
        if (k >= 3000) stuck();
    endtask
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] ctl(input int cs, input int w, input int c, input int f);
        return {24'h0, f[0], c[1:0], w[1:0], cs[2:0]};
    endfunction

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        sys_rst_i = 1'b1;
        {psel, penable, pwrite, pulse_en, ack_en} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        seed = 32'hE25B;
        num_errors = 0;
        n_tests = 0;
        cyc(4);
        sys_rst_i <= 1'b0;
        for (int a = 0; a < 6; a++) begin
            rdchk(8'(a * 4), {31'h0, a == 5});
        end
        // Unmapped place answers with an error and reads zero
        wr(8'h18, 32'hFF);
        chk({31'h0, err_q}, 32'h1);
        rdchk(8'h18, 32'h0);
        // Counter storage, including both extremes
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 32'h0 : (i == 1) ? 32'hFF : rnd() & 32'hFF;
            wr(A_CNT, v);
            rdchk(A_CNT, v);
            rdchk(`ETC_ADDR_STATUS, {30'h0, v == 32'hFF, v == 32'h0});
        end
        base = rnd() & 32'hFF;
        wr(A_CMP, base);
        rdchk(A_CMP, base);
        // Force strobe through every action; no flag, counter untouched
        for (int i = 0; i < 5; i++) begin
            wr(A_CTL, ctl(0, 0, acts[i], 1));
            cyc(2);
            chk({31'h0, cmp_out}, exps[i]);
        end
        rdchk(A_FLG, 32'h0);
        rdchk(A_CNT, v);
        rdchk(A_CTL, ctl(0, 0, 2, 0));
        wr(A_CTL, ctl(0, 0, 3, 1));
        wr(A_CTL, ctl(0, 3, 0, 0));
        cyc(2);
        chk({31'h0, cmp_out}, 32'h1);
        // Count write equal to compare hides the first match only
        wr(A_CTL, 32'h0);
        wr(A_CMP, 32'h10);
        wr(A_CNT, 32'h10);
        wr(A_CTL, ctl(1, 0, 0, 0));
        cyc(4);
        rdchk(A_FLG, 32'h0);
        cyc(300);
        rdchk(A_FLG, 32'h3);
        wr(A_CTL, 32'h0);
        wr(A_FLG, 32'h2);
        rdchk(A_FLG, 32'h1);
        wr(A_FLG, 32'h1);
        rdchk(A_FLG, 32'h0);
        // Requests need flag, enable and global enable; service clears
        wr(A_CMP, 32'h3);
        wr(A_CNT, 32'hFE);
        wr(`ETC_ADDR_MASK, 32'h3);
        wr(A_CTL, ctl(2, 0, 0, 0));
        cyc(50);
        wr(A_CTL, 32'h0);
        rdchk(A_FLG, 32'h3);
        chk({30'h0, ovf_irq, cmp_irq}, 32'h0);
        wr(`ETC_ADDR_STATUS, 32'h4);
        cyc(2);
        chk({30'h0, ovf_irq, cmp_irq}, 32'h3);
        ack_en <= 1'b1;
        cyc(6);
        chk({30'h0, ovf_irq, cmp_irq}, 32'h0);
        rdchk(A_FLG, 32'h0);
        ack_en <= 1'b0;
        wr(`ETC_ADDR_STATUS, 32'h0);
        // Pin edges of both polarities, then ignored while stopped
        for (int cs = 7; cs >= 6; cs--) begin
            wr(A_CNT, 32'h0);
            wr(A_CTL, ctl(cs, (7 - cs) * 2, 0, 0));
            base = 32'(pulses);
            pulse_en <= 1'b1;
            cyc(60);
            pulse_en <= 1'b0;
            cyc(12);
            rdchk(A_CNT, (32'(pulses) - base) % (cs == 7 ? 256 : 4));
        end
        base = rd_q;
        wr(A_CTL, ctl(0, 0, 2, 1));
        pulse_en <= 1'b1;
        cyc(30);
        pulse_en <= 1'b0;
        cyc(12);
        rdchk(A_CNT, base);
        // Fast PWM: compare held in buffer until the MAX tick
        wr(A_CTL, ctl(0, 3, 2, 0));
        wr(A_CMP, 32'h80);
        rdchk(A_CMP, 32'h80);
        wr(A_CNT, 32'hF0);
        wr(A_CTL, ctl(3, 3, 2, 0));
        poll(32'h20);
        wr(A_CMP, 32'h30);
        poll(32'h40);
        wr(A_CTL, ctl(0, 3, 2, 0));
        cyc(2);
        chk({31'h0, cmp_out}, 32'h1);
        rdchk(A_CMP, 32'h30);
        wr(A_CTL, ctl(3, 3, 2, 0));
        poll(32'h84);
        wr(A_CTL, ctl(0, 3, 2, 0));
        cyc(2);
        chk({31'h0, cmp_out}, 32'h0);
        test_done();
    end
endmodule
